// file: hw/light_load_pkg.sv
// Constants for the light-load phase manager.
// Assumes a 100 MHz system clock and comparator results already digitised.
package light_load_pkg;
  // Strap decode
  typedef enum logic [1:0] {STRAP_LOW, STRAP_FLOAT, STRAP_HIGH, STRAP_BAD} strap_level_t;
  // Phase two states
  typedef enum logic [1:0] {PH2_ON, PH2_RAMP, PH2_OFF} ph2_state_t;
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int HOLDOFF_US = 1500;
  localparam int HOLDOFF_CYCLES = HOLDOFF_US * CLK_MHZ;
  localparam int HOLD_W = 18;
  // Duty ramp: steps of the duty fraction, one per switching cycle
  localparam int DUTY_W = 8;
  localparam logic [DUTY_W-1:0] DUTY_FULL = 8'hff;
  localparam int RAMP_STEPS = 9;
  localparam logic [DUTY_W-1:0] DUTY_STEP = 8'h1d;
  localparam logic [DUTY_W-1:0] DUTY_ZERO = 8'h00;
  localparam logic [1:0] STRAP_LOW_CODE = 2'h0;
  localparam logic [1:0] STRAP_FLOAT_CODE = 2'h1;
  localparam logic [1:0] STRAP_HIGH_CODE = 2'h2;
endpackage

// file: hw/light_load_phase_manager.sv
// Light-load phase manager: mode decode, phase-two shedding, ramp and hold-off.
// Assumes comparator inputs and switching-cycle strobe are synchronous to clock.
//
// Summary of operation
// R01 - Strap selects continuous, emulation, or emulation plus shedding
// R02 - Shedding decided by average current comparators
// R03 - No shedding while externally synchronised
// R04 - Below shed threshold, drop phase two
// R05 - Ramp phase two duty down over cycles
// R06 - Above restore threshold, restore phase two immediately
// R07 - Peak trip on either phase restores immediately
// R08 - Block shedding 1.5ms after restore
// R09 - Diode emulation turns synchronous switch off
// R10 - Diode emulation forced during soft-start
// R11 - Pulse skipping on either phase in emulation
// R12 - Hysteresis between thresholds; counters time ramp, hold-off
`timescale 1ns/1ns
`default_nettype none
module light_load_phase_manager
  import light_load_pkg::*;
#(
  parameter int HOLDOFF_COUNT = HOLDOFF_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Configuration
  input wire logic [1:0] light_load_config_strap,
  input wire logic ext_sync_active,
  input wire logic soft_start_active,
  // Switching and comparators
  input wire logic switch_cycle_tick,
  input wire logic avg_below_shed,
  input wire logic avg_above_restore,
  input wire logic [1:0] peak_current_trip,
  input wire logic [1:0] phase_current_negative,
  input wire logic [1:0] phase_pulse_unneeded,
  // Controls out
  output logic diode_emulation_mode,
  output logic phase_shedding,
  output logic continuous_conduction_mode,
  output logic phase2_enable,
  output logic [DUTY_W-1:0] phase2_duty_scale,
  output logic [1:0] sync_switch_off,
  output logic [1:0] pulse_skip,
  output logic shed_holdoff
);
  import light_load_pkg::*;

  // Decode helper shared by the strap checks below
  function automatic logic strap_is(input logic [1:0] code, input logic [1:0] level);
    // Code three matches no level, so it falls back to continuous conduction
    strap_is = (code == level);
  endfunction

  // Strap is sampled once after reset release; it must not change while running.
  // A strap that moved mid-run would flip the mode under a live power stage.
  logic strap_taken_reg;
  logic [1:0] strap_reg;
  ph2_state_t state_reg;
  ph2_state_t state_next;
  logic [DUTY_W-1:0] duty_reg;
  logic [DUTY_W-1:0] duty_next;
  logic [HOLD_W-1:0] hold_reg;
  logic [HOLD_W-1:0] hold_next;
  logic emu_reg;
  logic shed_reg;
  logic cont_reg;
  logic en_reg;
  logic hold_flag_reg;
  logic [1:0] sw_off_reg;
  logic [1:0] skip_reg;

  // Mode decode
  wire logic emu_cfg;
  wire logic shed_cfg;
  wire logic emu_eff;
  wire logic shed_ok;
  assign emu_cfg = strap_is(strap_reg, STRAP_HIGH_CODE) ||
    strap_is(strap_reg, STRAP_FLOAT_CODE); // see R01
  assign shed_cfg = strap_is(strap_reg, STRAP_FLOAT_CODE); // see R01
  // Soft-start forces emulation so a pre-biased output cannot pull current backwards
  assign emu_eff = emu_cfg || soft_start_active; // see R10
  // Shedding only runs from the internal oscillator
  assign shed_ok = shed_cfg && !ext_sync_active; // see R03

  // Phase-two decisions
  wire logic restore_req;
  wire logic hold_busy;
  wire logic shed_req;
  wire logic back_on;
  wire logic ramp_last;
  wire logic [HOLD_W-1:0] hold_load;
  assign restore_req = avg_above_restore || (|peak_current_trip); // see R06 R07
  assign hold_busy = (hold_reg != '0);
  assign shed_req = shed_ok && avg_below_shed && !hold_busy; // see R02 R04 R08
  // Losing the shed permission counts as a restore, so phase two never stays parked
  assign back_on = restore_req || !shed_ok; // see R06 R07
  // Last step lands exactly on zero and never wraps below it
  assign ramp_last = (duty_reg <= DUTY_STEP); // see R05
  // Hold-off reload; the full count only fits because the counter is sized for it
  assign hold_load = HOLD_W'(HOLDOFF_COUNT); // see R08

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      strap_taken_reg <= 1'b0;
      strap_reg <= STRAP_LOW_CODE;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      strap_reg <= light_load_config_strap;
    end
  end

  // Restore wins over any shed or ramp, so a load step never waits on the ramp
  always_comb begin
    state_next = state_reg;
    duty_next = duty_reg;
    hold_next = hold_reg;
    if (hold_busy) begin
      hold_next = hold_reg - 1'b1; // see R08 R12
    end
    case (state_reg)
      PH2_ON: begin
        duty_next = DUTY_FULL;
        if (shed_req && !restore_req) begin
          state_next = PH2_RAMP; // see R04
        end
      end
      PH2_RAMP: begin
        // Restore wins even mid-ramp; the hold-off starts afresh
        if (back_on) begin
          state_next = PH2_ON; // see R06 R07
          duty_next = DUTY_FULL;
          hold_next = hold_load; // see R08
        end else if (switch_cycle_tick) begin
          if (ramp_last) begin
            duty_next = DUTY_ZERO;
            state_next = PH2_OFF;
          end else begin
            duty_next = duty_reg - DUTY_STEP; // see R05 R12
          end
        end
      end
      PH2_OFF: begin
        duty_next = DUTY_ZERO;
        // Between thresholds the phase stays off
        // Either restore cause brings the phase back at full duty at once
        if (back_on) begin
          state_next = PH2_ON; // see R06 R07 R12
          duty_next = DUTY_FULL;
          hold_next = hold_load; // see R08
        end
      end
      default: begin
        state_next = PH2_ON;
        duty_next = DUTY_FULL;
      end
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= PH2_ON;
      duty_reg <= DUTY_FULL;
      hold_reg <= '0;
    end else begin
      state_reg <= state_next;
      duty_reg <= duty_next;
      hold_reg <= hold_next;
    end
  end

  // Mode outputs
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      emu_reg <= 1'b0;
      shed_reg <= 1'b0;
      cont_reg <= 1'b1;
    end else begin
      emu_reg <= emu_eff; // see R01 R10
      shed_reg <= shed_ok; // see R03
      cont_reg <= !emu_eff; // see R01
    end
  end

  // Phase-two outputs
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      en_reg <= 1'b1;
      hold_flag_reg <= 1'b0;
    end else begin
      en_reg <= (state_next != PH2_OFF); // see R04
      hold_flag_reg <= (hold_next != '0); // see R08
    end
  end

  // Switch gating is one cycle late; the stage's own comparator is the fast guard
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sw_off_reg <= 2'h0;
      skip_reg <= 2'h0;
    end else begin
      sw_off_reg <= emu_eff ? phase_current_negative : 2'h0; // see R09
      skip_reg <= emu_eff ? phase_pulse_unneeded : 2'h0; // see R11
    end
  end

  assign diode_emulation_mode = emu_reg;
  assign phase_shedding = shed_reg;
  assign continuous_conduction_mode = cont_reg;
  assign phase2_enable = en_reg;
  assign phase2_duty_scale = duty_reg;
  assign sync_switch_off = sw_off_reg;
  assign pulse_skip = skip_reg;
  assign shed_holdoff = hold_flag_reg;
endmodule
`default_nettype wire

// file: verif/light_load_phase_manager_asserts.sv
// Checker bound to the phase manager ports.
// Assumes one clock and an async high reset.
`timescale 1ns/1ns
`default_nettype none
module llpm_asserts import light_load_pkg::*; (
  input wire logic clock, sys_rst, ext_sync_active, soft_start_active, avg_above_restore,
  input wire logic [1:0] peak_current_trip,
  input wire logic diode_emulation_mode, phase_shedding, continuous_conduction_mode,
  input wire logic phase2_enable, shed_holdoff,
  input wire logic [DUTY_W-1:0] phase2_duty_scale
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  cond_mode_a: assert property (continuous_conduction_mode != diode_emulation_mode)
    else $error("mode");
  sync_shed_a: assert property ($past(ext_sync_active) |-> !phase_shedding)
    else $error("sync");
  trip_add_a: assert property (|peak_current_trip && !phase2_enable |=> phase2_enable)
    else $error("trip");
  level_add_a: assert property (avg_above_restore |=> phase2_duty_scale == DUTY_FULL)
    else $error("add");
  hold_start_a: assert property ($rose(phase2_enable) |-> shed_holdoff)
    else $error("hold");
  off_zero_a: assert property (!phase2_enable |-> phase2_duty_scale == DUTY_ZERO)
    else $error("off");
  duty_step_a: assert property ($past(phase2_duty_scale) > phase2_duty_scale |->
    $past(phase2_duty_scale) - phase2_duty_scale <= DUTY_STEP) else $error("step");
  soft_de_a: assert property ($past(soft_start_active) |-> diode_emulation_mode)
    else $error("soft");
endmodule
bind light_load_phase_manager llpm_asserts u_llpm_asserts (.*);
`default_nettype wire

// file: verif/stage_model.sv
// Stand-in power stage: cycle strobe and peak trip.
// Assumes the manager's clock; trips phase one only to test the OR.
`timescale 1ns/1ns
`default_nettype none
module stage_model (
  input wire logic clock, load_jump,
  output logic switch_cycle_tick,
  output logic [1:0] peak_current_trip
);
  logic [1:0] div_reg = 2'h0;
  always_ff @(posedge clock) div_reg <= div_reg + 2'h1;
  assign switch_cycle_tick = &div_reg;
  assign peak_current_trip = {1'b0, load_jump};
endmodule
`default_nettype wire

// file: verif/test_light_load_phase_manager.sv
// Bench: phase manager with a stand-in power stage.
// Assumes 100 MHz; hold-off cut to HOLD cycles.
`timescale 1ns/1ns
`default_nettype none
module test_light_load_phase_manager;
  import light_load_pkg::*;
  localparam int HOLD = 20;
  localparam logic [8:0] ON = {1'b1, DUTY_FULL};
  logic clock = 0, sys_rst = 1, ext_sync_active = 0, soft_start_active = 0, load_jump = 0;
  logic avg_below_shed = 0, avg_above_restore = 0, diode_emulation_mode, phase_shedding;
  logic continuous_conduction_mode, phase2_enable, shed_holdoff, switch_cycle_tick;
  logic [1:0] light_load_config_strap = 2'h0, peak_current_trip, sync_switch_off, pulse_skip;
  logic [1:0] phase_current_negative = 2'h3, phase_pulse_unneeded = 2'h2;
  logic [DUTY_W-1:0] phase2_duty_scale;
  wire [8:0] p2 = {phase2_enable, phase2_duty_scale};
  wire [4:0] emu = {diode_emulation_mode, sync_switch_off, pulse_skip};
  int n_fail = 0, checks_done = 0, cyc = 0;
  stage_model u_stage_model (.*);
  light_load_phase_manager #(.HOLDOFF_COUNT(HOLD)) u_light_load_phase_manager (.*);
  initial forever #5 clock = ~clock;
  always @(posedge clock) if (++cyc > 3000) begin n_fail++; close_out; end
  task step(int n); repeat (n) @(posedge clock); #1; endtask
  task chk(logic [8:0] seen, want);
    checks_done++;
    if (seen !== want) begin n_fail++; $display("MISMATCH %0t %h %h", $time, seen, want); end
  endtask
  // Strap is taken once, so every mode needs its own reset
  task go(logic [1:0] code);
    sys_rst = 1; light_load_config_strap = code; step(5); sys_rst = 0; step(3);
  endtask
  task t_strap;
    for (int c = 0; c < 4; c++) begin
      go(c[1:0]);
      chk({emu, phase_shedding, continuous_conduction_mode}, (c % 3) ? {5'h1e, c == 1, 1'b0} : 9'h1);
    end
    $display("strap done");
  endtask
  task t_shed;
    go(2'h1); avg_below_shed = 1; step(50);
    chk(p2, 9'h0);
    avg_below_shed = 0; step(5);
    chk(p2, 9'h0);
    load_jump = 1; step(1); load_jump = 0; avg_below_shed = 1;
    chk(p2, ON);
    step(HOLD - 3);
    chk({shed_holdoff, phase2_duty_scale}, ON);
    step(60);
    chk(p2, 9'h0);
    avg_below_shed = 0; avg_above_restore = 1; step(1);
    chk(p2, ON);
    avg_above_restore = 0; avg_below_shed = 0; $display("shed done");
  endtask
  task t_ext;
    go(2'h1); ext_sync_active = 1; avg_below_shed = 1; step(50);
    chk({phase_shedding, phase2_duty_scale}, {1'b0, DUTY_FULL});
    ext_sync_active = 0; avg_below_shed = 0; $display("ext sync done");
  endtask
  task t_soft;
    go(2'h0); soft_start_active = 1; step(3);
    chk(emu, 9'h1e);
    soft_start_active = 0; $display("soft start done");
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    t_strap; t_shed; t_ext; t_soft; close_out;
  end
endmodule
`default_nettype wire
